// >>> dcp_pkg.sv
package dcp_pkg;

    // Command pin bundle after synchronisation
    typedef struct packed {
        logic selB;
        logic rowB;
        logic colB;
        logic wrB;
        logic [2:0] bank;
        logic [13:0] addr;
    } dcp_cmd_s;

    localparam int CMD_W = 21;

    // One queued pattern read
    typedef struct packed {
        logic valid;
        logic chop;
        logic upper;
        logic [1:0] loc;
    } dcp_req_s;

    // Mode register select on the bank pins
    localparam logic [2:0] MR_ZERO_SEL = 3'h0;
    localparam logic [2:0] MR_ONE_SEL = 3'h1;
    localparam logic [2:0] MR_THREE_SEL = 3'h3;

    // Address bit positions used by commands
    localparam int ADDR_LOC_LSB = 0;
    localparam int ADDR_PAT_EN = 2;
    localparam int ADDR_ORDER = 2;
    localparam int ADDR_CHOP = 12;
    localparam int MR0_CAS_LSB = 4;
    localparam int MR1_AL_LSB = 3;

    // Burst mode field of mode register zero
    localparam logic [1:0] BURST_FIXED8 = 2'h0;
    localparam logic [1:0] BURST_OTF = 2'h1;
    localparam logic [1:0] BURST_FIXED4 = 2'h2;

    // Latency arithmetic
    localparam logic [4:0] CAS_BASE = 5'h04;
    localparam int PIPE_DEPTH = 32;
    localparam logic [3:0] BEATS_FULL = 4'h8;
    localparam logic [3:0] BEATS_CHOP = 4'h4;

    // Predefined calibration pattern, beat 0 in the LSB
    localparam logic [7:0] CAL_PATTERN = 8'haa;
    localparam logic [7:0] RESERVED_PATTERN = 8'h00;
    localparam logic [1:0] LOC_CAL = 2'h0;

    // Register port map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MODE = 8'h08;

    // Reset values
    localparam logic [1:0] MR0_BURST_RST = 2'h0;
    localparam logic [2:0] MR0_CAS_RST = 3'h1;
    localparam logic [1:0] MR1_AL_RST = 2'h0;
    localparam logic [7:0] ILLEGAL_RST = 8'h00;

endpackage : dcp_pkg

// >>> dcp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module dcp_sync
    import dcp_pkg::*;
#(
    parameter int WIDTH = CMD_W,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    // Two flops per bit; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    stage1[i] <= RST_VAL[i];
                    dout[i] <= RST_VAL[i];
                end else begin
                    stage1[i] <= din[i];
                    dout[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule : dcp_sync

`default_nettype wire

// >>> dcp_beat_gen.sv
`timescale 1ns/1ps
`default_nettype none

module dcp_beat_gen
    import dcp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire dcp_req_s launch,
    output logic beatValid,
    output logic beatBit
);

    logic [3:0] left;
    logic [2:0] index;
    logic [7:0] pattern;
    logic [3:0] next_left;
    logic [2:0] next_index;
    logic [7:0] next_pattern;

    // A new launch restarts the burst; beats step from the start index
    always_comb begin
        next_left = left;
        next_index = index;
        next_pattern = pattern;
        if (launch.valid) begin
            // [R10] Location selects pattern
            next_pattern = (launch.loc == LOC_CAL) ? CAL_PATTERN : RESERVED_PATTERN;
            // [R4] Nibble from order bit
            next_index = (launch.chop && launch.upper) ? 3'h4 : 3'h0;
            // [R3] Full burst order 0-7
            next_left = launch.chop ? BEATS_CHOP : BEATS_FULL;
        end else if (left != 4'h0) begin
            next_left = left - 4'h1;
            next_index = index + 3'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            left <= 4'h0;
            index <= 3'h0;
            pattern <= 8'h00;
        end else begin
            left <= next_left;
            index <= next_index;
            pattern <= next_pattern;
        end
    end

    // [R9] Beat n is bit n
    assign beatBit = pattern[index];
    assign beatValid = (left != 4'h0);

endmodule : dcp_beat_gen

`default_nettype wire

// >>> dcp_pattern_readout.sv
// Function
// [R1] DQ[0] carries pattern, others copy it
// [R2] Controller keeps A[1:0] at zero
// [R3] Eight-beat read returns beats 0 to 7
// [R4] Chopped read: A2 picks lower/upper nibble
// [R5] Bank, A10 and other column bits ignored
// [R6] A12 picks chop when on-the-fly enabled
// [R7] Data starts after AL plus CL
// [R8] Controller locks DLL before pattern reads
// [R9] Burst bit 0 is LSB, 7 MSB
// [R10] Location zero gives 0,1,0,1 pattern
// [R11] Controller precharges all, waits tRP first
// [R12] Mode three A2 set enables pattern reads
// [R13] Controller waits tMRD and tMOD after enable
// [R14] Controller issues no writes in pattern mode
// [R15] Controller may repeat pattern reads freely
// [R16] Controller waits read recovery before exit
// [R17] Mode three A2 clear restores array access
// [R18] Only reads; auto-precharge read acts plain
`timescale 1ns/1ps
`default_nettype none

module dcp_pattern_readout
    import dcp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cmdSelB,
    input wire logic rowStrobeB,
    input wire logic colStrobeB,
    input wire logic writeEnB,
    input wire logic [2:0] bankAddr,
    input wire logic [13:0] addrBus,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    output logic [7:0] dqOut,
    output logic [7:0] dqOe,
    output logic dqsOut,
    output logic dqsOe
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin capture and command decode

    dcp_cmd_s cmd;
    logic [CMD_W-1:0] cmdRaw;

    // Pins come from the controller's domain; idle deselect at reset
    dcp_sync #(
        .WIDTH(CMD_W),
        .RST_VAL({1'b1, 3'h7, 17'h00000})
    ) u_cmd_sync (
        .clock(clock),
        .rst_b(rst_b),
        .din({cmdSelB, rowStrobeB, colStrobeB, writeEnB, bankAddr, addrBus}),
        .dout(cmdRaw)
    );

    assign cmd = dcp_cmd_s'(cmdRaw);

    logic isMrs;
    logic isRead;
    logic isWrite;
    logic isOther;

    // Command truth table on the low-active strobes
    assign isMrs = !cmd.selB && !cmd.rowB && !cmd.colB && !cmd.wrB;
    assign isRead = !cmd.selB && cmd.rowB && !cmd.colB && cmd.wrB;
    assign isWrite = !cmd.selB && cmd.rowB && !cmd.colB && !cmd.wrB;
    assign isOther = !cmd.selB && !(cmd.rowB && cmd.colB && cmd.wrB) && !isRead && !isMrs;

    ////////////////////////////////////////////////////////////////////////////
    // Mode register state

    logic [1:0] mr0Burst;
    logic [2:0] mr0Cas;
    logic [1:0] mr1Al;
    logic patternMode;
    logic [1:0] patternLoc;
    logic [1:0] next_mr0Burst;
    logic [2:0] next_mr0Cas;
    logic [1:0] next_mr1Al;
    logic next_patternMode;
    logic [1:0] next_patternLoc;

    // Only the fields this block uses are kept from each mode write
    always_comb begin
        next_mr0Burst = mr0Burst;
        next_mr0Cas = mr0Cas;
        next_mr1Al = mr1Al;
        next_patternMode = patternMode;
        next_patternLoc = patternLoc;
        if (isMrs) begin
            case (cmd.bank)
                MR_ZERO_SEL: begin
                    next_mr0Burst = cmd.addr[1:0];
                    next_mr0Cas = cmd.addr[MR0_CAS_LSB +: 3];
                end
                MR_ONE_SEL: begin
                    next_mr1Al = cmd.addr[MR1_AL_LSB +: 2];
                end
                MR_THREE_SEL: begin
                    // [R12] Enable and pick location
                    // [R17] Clear returns to array
                    next_patternMode = cmd.addr[ADDR_PAT_EN];
                    next_patternLoc = cmd.addr[ADDR_LOC_LSB +: 2];
                end
                default: begin
                    next_patternMode = patternMode;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mr0Burst <= MR0_BURST_RST;
            mr0Cas <= MR0_CAS_RST;
            mr1Al <= MR1_AL_RST;
            patternMode <= 1'b0;
            patternLoc <= LOC_CAL;
        end else begin
            mr0Burst <= next_mr0Burst;
            mr0Cas <= next_mr0Cas;
            mr1Al <= next_mr1Al;
            patternMode <= next_patternMode;
            patternLoc <= next_patternLoc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read latency

    logic [4:0] casLat;
    logic [4:0] addLat;
    logic [4:0] readLat;
    logic [4:0] tapIdx;

    // [R7] Latency is AL plus CL
    always_comb begin
        casLat = CAS_BASE + {2'h0, mr0Cas};
        case (mr1Al)
            2'h1: addLat = casLat - 5'h01;
            2'h2: addLat = casLat - 5'h02;
            default: addLat = 5'h00;
        endcase
        readLat = casLat + addLat;
        // Sums reach at most 21, inside the pipe depth, so no clamp is applied
        tapIdx = (readLat == 5'h00) ? 5'h00 : readLat - 5'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request formation and latency pipe

    dcp_req_s newReq;

    // Only bank-free fields are taken from a read
    always_comb begin
        newReq = '0;
        // [R18] Auto-precharge bit has no effect
        // [R5] Bank and column bits dropped
        newReq.valid = isRead && patternMode;
        newReq.loc = patternLoc;
        // [R4] Order bit matters only chopped
        newReq.upper = cmd.addr[ADDR_ORDER];
        // [R6] Chop select per command
        case (mr0Burst)
            BURST_FIXED4: newReq.chop = 1'b1;
            BURST_OTF: newReq.chop = !cmd.addr[ADDR_CHOP];
            default: newReq.chop = 1'b0;
        endcase
    end

    dcp_req_s pipe [PIPE_DEPTH];
    dcp_req_s next_pipe [PIPE_DEPTH];

    // Plain shift; a read is launched when it reaches the latency tap
    always_comb begin
        next_pipe[0] = newReq;
        for (int k = 1; k < PIPE_DEPTH; k++) begin
            next_pipe[k] = pipe[k-1];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < PIPE_DEPTH; k++) begin
                pipe[k] <= '0;
            end
        end else begin
            for (int k = 0; k < PIPE_DEPTH; k++) begin
                pipe[k] <= next_pipe[k];
            end
        end
    end

    logic beatValid;
    logic beatBit;

    dcp_beat_gen u_beat_gen (
        .clock(clock),
        .rst_b(rst_b),
        .launch(pipe[tapIdx]),
        .beatValid(beatValid),
        .beatBit(beatBit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data pins

    logic [7:0] next_dqOut;
    logic [7:0] next_dqOe;
    logic next_dqsOut;
    logic next_dqsOe;

    // Strobe toggles per beat so the capture side sees an edge each beat
    always_comb begin
        // [R1] Same bit on every lane
        next_dqOut = beatValid ? {8{beatBit}} : 8'h00;
        next_dqOe = {8{beatValid}};
        next_dqsOut = beatValid ? !dqsOut : 1'b0;
        next_dqsOe = beatValid;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dqOut <= 8'h00;
            dqOe <= 8'h00;
            dqsOut <= 1'b0;
            dqsOe <= 1'b0;
        end else begin
            dqOut <= next_dqOut;
            dqOe <= next_dqOe;
            dqsOut <= next_dqsOut;
            dqsOe <= next_dqsOe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Illegal command counter

    logic [7:0] illegalCount;
    logic [7:0] next_illegalCount;
    logic clearCount;
    logic badCmd;

    assign clearCount = regWrite && (regAddr == REG_CTRL) && regWrData[0];
    // [R14] Writes in pattern mode are dropped
    assign badCmd = patternMode && (isWrite || isOther);

    // A bad command in the clearing cycle still counts
    always_comb begin
        next_illegalCount = illegalCount;
        if (clearCount) begin
            next_illegalCount = ILLEGAL_RST;
        end
        if (badCmd && (clearCount || (illegalCount != 8'hff))) begin
            next_illegalCount = (clearCount ? ILLEGAL_RST : illegalCount) + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            illegalCount <= ILLEGAL_RST;
        end else begin
            illegalCount <= next_illegalCount;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port

    logic [31:0] next_regRdData;

    // Data stands for one cycle after the read strobe, zero otherwise
    always_comb begin
        next_regRdData = 32'h00000000;
        if (regRead) begin
            case (regAddr)
                REG_STATUS: next_regRdData = {16'h0000, illegalCount, 4'h0,
                                              beatValid, patternLoc, patternMode};
                REG_MODE: next_regRdData = {20'h00000, readLat, mr1Al, mr0Cas, mr0Burst};
                default: next_regRdData = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 32'h00000000;
        end else begin
            regRdData <= next_regRdData;
        end
    end

endmodule : dcp_pattern_readout

`default_nettype wire

// >>> dcp_readout_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_readout_checker
    import dcp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cmdSelB,
    input wire logic rowStrobeB,
    input wire logic colStrobeB,
    input wire logic writeEnB,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic [31:0] regRdData,
    input wire logic [7:0] dqOut,
    input wire logic [7:0] dqOe,
    input wire logic dqsOut,
    input wire logic dqsOe
);
    default clocking dcb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [4:0] rdAge;
    logic [4:0] next_rdAge;
    logic rdPin;
    ////////////////////////////////////////////////////////////////
    // Cycles since a read on the pins; saturates so it never wraps
    assign rdPin = !cmdSelB && rowStrobeB && !colStrobeB && writeEnB;
    always_comb begin
        next_rdAge = (rdAge == 5'h1f) ? rdAge : rdAge + 5'h01;
        if (rdPin) begin
            next_rdAge = 5'h00;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdAge <= 5'h1f;
        end else begin
            rdAge <= next_rdAge;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_lanes_equal: assert property (dqOe[0] |-> dqOut == 8'h00 || dqOut == 8'hff)
        else $error("lanes differ");
    a_oe_uniform: assert property (dqOe == {8{dqsOe}})
        else $error("enables differ");
    a_idle_quiet: assert property (!dqsOe |-> dqOut == 8'h00 && !dqsOut)
        else $error("idle lines driven");
    a_first_beat: assert property ($rose(dqsOe) |-> dqsOut && dqOut == 8'h00)
        else $error("first beat wrong");
    a_beat_alternate: assert property (dqOut[0] |-> $past(dqsOe) && !$past(dqOut[0]))
        else $error("pattern not alternating");
    a_min_beats: assert property ($rose(dqsOe) |-> dqsOe [*4])
        else $error("burst too short");
    a_read_window: assert property ($rose(dqsOe) |-> rdAge <= 5'd24)
        else $error("burst without recent read");
    a_reg_unmapped: assert property (regRead && regAddr != REG_STATUS && regAddr != REG_MODE
        |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    a_reg_idle: assert property (!$past(regRead) |-> regRdData == 32'h0)
        else $error("read data outside slot");
endmodule : dcp_readout_checker
bind dcp_pattern_readout dcp_readout_checker i_chk (
    .clock, .rst_b, .cmdSelB, .rowStrobeB, .colStrobeB, .writeEnB,
    .regAddr, .regRead, .regRdData, .dqOut, .dqOe, .dqsOut, .dqsOe
);
`default_nettype wire

// >>> dcp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_ctrl_model
    import dcp_pkg::*;
#(
    parameter int T_RP = 4,
    parameter int T_MOD = 12,
    parameter int T_MPRR = 4,
    parameter int T_LOCK = 16
) (
    input wire logic clock,
    output logic cmdSelB,
    output logic rowStrobeB,
    output logic colStrobeB,
    output logic writeEnB,
    output logic [2:0] bankAddr,
    output logic [13:0] addrBus
);
    // Deselected at time zero
    initial begin
        cmdSelB = 1'b1;
        {rowStrobeB, colStrobeB, writeEnB} = 3'h7;
        bankAddr = 3'h0;
        addrBus = 14'h0;
    end
    ////////////////////////////////////////////////////////////////
    // One command cycle; when idle the address is inverted so stale values never pass
    task send(input logic [2:0] rcw, input logic [2:0] ba, input logic [13:0] a, input bit idle);
        @(posedge clock);
        cmdSelB <= 1'b0;
        {rowStrobeB, colStrobeB, writeEnB} <= rcw;
        bankAddr <= ba;
        addrBus <= a;
        if (idle) begin
            @(posedge clock);
            cmdSelB <= 1'b1;
            bankAddr <= ~ba;
            addrBus <= ~a;
        end
    endtask : send
    task mrs(input logic [2:0] ba, input logic [13:0] a);
        send(3'h0, ba, a, 1'b1);
        repeat (T_MOD) @(posedge clock);
    endtask : mrs
    task lock_dll();
        repeat (T_LOCK) @(posedge clock);
    endtask : lock_dll
    // Precharge, enable, settle; no writes follow
    task enter(input logic [1:0] loc);
        send(3'h2, 3'h0, 14'h0400, 1'b1);
        repeat (T_RP) @(posedge clock);
        mrs(MR_THREE_SEL, {11'h0, 1'b1, loc});
    endtask : enter
    // Low address bits forced to zero, repeatable
    task read(input bit up, input bit full, input logic [2:0] ba, input logic [13:0] junk,
              input bit idle);
        send(3'h5, ba, {junk[13], full, junk[11:3], up, 2'b00}, idle);
    endtask : read
    task exitm();
        repeat (T_MPRR) @(posedge clock);
        mrs(MR_THREE_SEL, 14'h0);
    endtask : exitm
endmodule : dcp_ctrl_model
`default_nettype wire

// >>> test_dcp_pattern_readout.sv
`timescale 1ns/1ps
`default_nettype none
module test_dcp_pattern_readout;
    import dcp_pkg::*;
    logic clock, rst_b, cmdSelB, rowStrobeB, colStrobeB, writeEnB, regWrite, regRead;
    logic dqsOut, dqsOe;
    logic [2:0] bankAddr;
    logic [13:0] addrBus;
    logic [7:0] regAddr, dqOut, dqOe;
    logic [31:0] regWrData, regRdData, d;
    int n_fail, total_checks;
    dcp_ctrl_model i_ctrl (.clock(clock), .cmdSelB(cmdSelB), .rowStrobeB(rowStrobeB),
        .colStrobeB(colStrobeB), .writeEnB(writeEnB), .bankAddr(bankAddr), .addrBus(addrBus));
    dcp_pattern_readout i_dut (.clock(clock), .rst_b(rst_b), .cmdSelB(cmdSelB),
        .rowStrobeB(rowStrobeB), .colStrobeB(colStrobeB), .writeEnB(writeEnB),
        .bankAddr(bankAddr), .addrBus(addrBus), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .dqOut(dqOut),
        .dqOe(dqOe), .dqsOut(dqsOut), .dqsOe(dqsOe));
    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task tally_and_finish();
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Register port: one-cycle strobes, data only in the following cycle
    task reg_rd(input logic [7:0] a);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask : reg_rd
    task reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : reg_wr
    // Bounded wait for the first beat, then every beat and strobe phase
    task burst(input int lat, input int n, input logic [15:0] pat);
        int k;
        k = 0;
        do begin
            @(posedge clock);
            #1 k++;
        end while (dqOe !== 8'hff && k < 40);
        check(k, lat + 3);
        for (int i = 0; i < n; i++) begin
            check({dqOe, dqOut}, {8'hff, {8{pat[i]}}});
            check(dqsOut, !i[0]);
            @(posedge clock);
            #1;
        end
        check(dqOe, 8'h00);
    endtask : burst
    task quiet(input int n);
        repeat (n) begin
            @(posedge clock);
            #1 check(dqOe, 8'h00);
        end
    endtask : quiet
    ////////////////////////////////////////////////////////////////
    // Full, chopped, back-to-back, reserved, latency, refused write, exit
    task t_enter_full();
        i_ctrl.read(0, 1, 3'h0, 14'h0, 1);
        quiet(16);
        i_ctrl.mrs(MR_ZERO_SEL, 14'h0011);
        i_ctrl.enter(LOC_CAL);
        reg_rd(REG_STATUS);
        check(d[2:0], 3'h1);
        i_ctrl.read(0, 1, 3'h5, 14'h2ff8, 1);
        burst(5, 8, 16'h00aa);
    endtask : t_enter_full
    task t_chop();
        i_ctrl.read(0, 0, 3'h2, 14'h0, 1);
        burst(5, 4, 16'h00aa);
        i_ctrl.read(1, 0, 3'h1, 14'h0400, 1);
        burst(5, 4, 16'h000a);
        // Fixed chop ignores a full-length request; mode writes only outside pattern mode
        i_ctrl.exitm();
        i_ctrl.mrs(MR_ZERO_SEL, 14'h0012);
        i_ctrl.enter(LOC_CAL);
        i_ctrl.read(0, 1, 3'h0, 14'h0, 1);
        burst(5, 4, 16'h00aa);
        i_ctrl.exitm();
        i_ctrl.mrs(MR_ZERO_SEL, 14'h0011);
        i_ctrl.enter(LOC_CAL);
    endtask : t_chop
    task t_back();
        i_ctrl.read(0, 1, 3'h0, 14'h0, 1);
        fork
            burst(5, 16, 16'haaaa);
            begin
                repeat (6) @(posedge clock);
                i_ctrl.read(0, 1, 3'h0, 14'h0, 1);
            end
        join
    endtask : t_back
    task t_reserved_latency();
        i_ctrl.exitm();
        i_ctrl.enter(2'h1);
        i_ctrl.read(0, 1, 3'h0, 14'h0, 1);
        burst(5, 8, 16'h0000);
        i_ctrl.exitm();
        i_ctrl.mrs(MR_ONE_SEL, 14'h0008);
        i_ctrl.enter(LOC_CAL);
        reg_rd(REG_MODE);
        check(d[11:7], 5'h09);
        i_ctrl.read(0, 1, 3'h0, 14'h0, 1);
        burst(9, 8, 16'h00aa);
        i_ctrl.exitm();
        i_ctrl.mrs(MR_ONE_SEL, 14'h0);
        i_ctrl.enter(LOC_CAL);
    endtask : t_reserved_latency
    task t_write_exit();
        i_ctrl.send(3'h4, 3'h0, 14'h0, 1);
        quiet(12);
        reg_rd(REG_STATUS);
        check(d[15:8], 8'h01);
        reg_wr(REG_CTRL, 32'h1);
        reg_rd(REG_STATUS);
        check(d[15:8], 8'h00);
        i_ctrl.exitm();
        reg_rd(REG_STATUS);
        check(d[0], 1'b0);
        i_ctrl.read(0, 1, 3'h0, 14'h0, 1);
        quiet(16);
    endtask : t_write_exit
    ////////////////////////////////////////////////////////////////
    // 200 MHz clock and watchdog
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #20000;
        n_fail++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {rst_b, regWrite, regRead, regAddr, regWrData} = '0;
        n_fail = 0;
        total_checks = 0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        i_ctrl.lock_dll();
        reg_rd(REG_MODE);
        check(d, 32'h284);
        reg_rd(8'h10);
        check(d, 32'h0);
        t_enter_full();
        t_chop();
        t_back();
        t_reserved_latency();
        t_write_exit();
        tally_and_finish();
    end
endmodule : test_dcp_pattern_readout
`default_nettype wire
